// ### core/gsi_pkg.sv
// Contract
// - bit 19 reads live vertical_blank_signal, low active
// - bits 18,17 read live syncs, low active
// - bit 15 reports master or slave role
// - bit 14 clip flag set on clipping
// - bit 13 masks clip interrupt
// - bit 12 set on drawing completion
// - bit 11 masks drawing-done interrupt
// - bit 10 vertical_blank_signal occurred, zero means occurred
// - bit 9 masks vertical_blank_signal interrupt
// - bit 8 global interrupt enable
// - bit 7 reports extra wait state
// - bits 6-5 position code selects base
// - position code per colour controller
// - bits 4-2 frame buffer size code
// - bits 1-0 pixel depth code
// - pixel depth captured at reset only
// - drawing-active bit while command executes
package gsi_pkg;
   // ==========================================================
   // register map
   localparam logic [3:0]  GSI_ADDR_CSR_ONE = 4'h0;
   localparam logic [3:0]  GSI_ADDR_CSR_TWO = 4'h2;
   localparam int          GSI_AW           = 4;
   localparam int          GSI_DW           = 32;
   // ==========================================================
   // field positions
   localparam int B_BLANK_LVL  = 19;
   localparam int B_VSYNC_LVL  = 18;
   localparam int B_HSYNC_LVL  = 17;
   localparam int B_DAC        = 16;
   localparam int B_MASTER     = 15;
   localparam int B_CLF        = 14;
   localparam int B_CLIP_MASK  = 13;
   localparam int B_DDF        = 12;
   localparam int B_DONE_MASK  = 11;
   localparam int B_VBF        = 10;
   localparam int B_BLANK_MASK = 9;
   localparam int B_GIE        = 8;
   localparam int B_WAIT       = 7;
   localparam int B_POSH = 6;
   localparam int B_POSL = 5;
   localparam int B_FBH  = 4;
   localparam int B_FBL  = 2;
   localparam int B_PDH  = 1;
   localparam int B_PDL  = 0;
   localparam int B_BUSY = 1;
   // ==========================================================
   // codes and bases
   localparam logic [1:0]  POS_RED   = 2'h0;
   localparam logic [1:0]  POS_BLUE  = 2'h1;
   localparam logic [1:0]  POS_GREEN = 2'h2;
   localparam logic [31:0] BASE_POS0 = 32'hFFF89100;
   localparam logic [31:0] BASE_POS1 = 32'hFFF89200;
   localparam logic [31:0] BASE_POS2 = 32'hFFF89300;
   localparam logic [1:0]  PD_8BPP   = 2'h0;
   localparam logic [1:0]  PD_24BPP  = 2'h2;
   localparam logic [2:0]  FB_MAX    = 3'h4;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic       dac_type_flag;
      logic       master_role_flag;
      logic       extra_wait_flag;
      logic [1:0] position_code;
      logic [2:0] framebuf_size_code;
      logic [1:0] pixel_depth_code;
   } gsi_strap_t;
   typedef struct packed {
      logic vertical_blank_signal;
      logic vert_sync;
      logic horiz_sync;
   } gsi_raster_t;
   typedef struct packed {
      logic clip;
      logic done;
      logic busy;
   } gsi_draw_t;
   typedef struct packed {
      logic [GSI_AW-1:0] addr;
      logic [GSI_DW-1:0] wdata;
      logic              wr;
      logic              rd;
   } gsi_bus_t;
endpackage

// ### core/gsi_flag.sv
`timescale 1ns/1ps
// sticky event flag, set beats clear
module gsi_flag #(
   parameter logic IDLE = 1'b0
) (
   input  wire logic clock_i,
   input  wire logic nrst_i,
   input  wire logic set_i,
   input  wire logic wr_i,
   input  wire logic wval_i,
   output logic      flag_o
);
   typedef struct packed {
      logic f;
   } gsi_flag_st_t;
   gsi_flag_st_t s_q;
   gsi_flag_st_t s_d;
   // ==========================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      if (wr_i && wval_i == IDLE)
      begin
         s_d.f = IDLE;
      end
      if (set_i)
      begin
         s_d.f = ~IDLE;
      end
   end
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         s_q <= '{f: IDLE};
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign flag_o = s_q.f;
endmodule

// ### core/gsi_base.sv
`timescale 1ns/1ps
// position code to register base decode
module gsi_base
   import gsi_pkg::*;
(
   input  wire logic [1:0]  position_code_i,
   output logic      [31:0] base_o,
   output logic             valid_o
);
   always_comb
   begin
      valid_o = 1'b1;
      case (position_code_i)
         POS_RED:   base_o = BASE_POS0;
         POS_BLUE:  base_o = BASE_POS1;
         POS_GREEN: base_o = BASE_POS2;
         default:
         begin
            base_o  = BASE_POS0;
            valid_o = 1'b0;
         end
      endcase
   end
endmodule

// ### core/gsi_top.sv
`timescale 1ns/1ps
module gsi_top
   import gsi_pkg::*;
(
   input  wire logic                clock_i,
   input  wire logic                nrst_i,
   input  wire gsi_pkg::gsi_bus_t   bus_i,
   input  wire gsi_pkg::gsi_raster_t raster_n_i,
   input  wire gsi_pkg::gsi_draw_t  draw_i,
   input  wire gsi_pkg::gsi_strap_t strap_i,
   output logic [GSI_DW-1:0]        rdata_o,
   output logic                     irq_o,
   output logic [31:0]              base_o,
   output logic                     base_valid_o
);
   import gsi_pkg::*;
   typedef enum logic [0:0] {
      ST_CAPTURE = 1'b0,
      ST_RUN     = 1'b1
   } gsi_ph_t;
   typedef struct packed {
      gsi_ph_t          ph;
      gsi_strap_t       strap;
      logic             clip_mask;
      logic             done_mask;
      logic             blank_mask;
      logic             gie;
      logic             blank_prev;
      logic [GSI_DW-1:0] rdata;
      logic             irq;
      logic [31:0]      base;
      logic             base_ok;
   } gsi_st_t;
   gsi_st_t s_q;
   gsi_st_t s_d;
   logic    clf;
   logic    ddf;
   logic    vbf;
   logic    wr2;
   logic    vb_rise;
   logic [31:0] base_c;
   logic        base_ok_c;
   function automatic logic hit(input logic [GSI_AW-1:0] a, input logic [GSI_AW-1:0] r);
      hit = (a == r);
   endfunction
   assign wr2     = bus_i.wr && hit(bus_i.addr, GSI_ADDR_CSR_TWO);
   // vertical_blank_signal entry edge (input is active low)
   assign vb_rise = s_q.blank_prev && !raster_n_i.vertical_blank_signal;
   // ==========================================================
   // event flags
   gsi_flag #(.IDLE(1'b0)) u_clip (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .set_i   (draw_i.clip),
      .wr_i    (wr2),
      .wval_i  (bus_i.wdata[B_CLF]),
      .flag_o  (clf)
   );
   gsi_flag #(.IDLE(1'b0)) u_done (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .set_i   (draw_i.done),
      .wr_i    (wr2),
      .wval_i  (bus_i.wdata[B_DDF]),
      .flag_o  (ddf)
   );
   gsi_flag #(.IDLE(1'b1)) u_vertical_blank_signal (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .set_i   (vb_rise),
      .wr_i    (wr2),
      .wval_i  (bus_i.wdata[B_VBF]),
      .flag_o  (vbf)
   );
   gsi_base u_base (
      .position_code_i (s_q.strap.position_code),
      .base_o          (base_c),
      .valid_o         (base_ok_c)
   );
   // ==========================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      case (s_q.ph)
         ST_CAPTURE:
         begin
            s_d.strap = strap_i;
            s_d.ph    = ST_RUN;
         end
         ST_RUN:
         begin
            s_d.ph = ST_RUN;
         end
         default:
         begin
            s_d.ph = ST_CAPTURE;
         end
      endcase
      if (wr2)
      begin
         s_d.clip_mask  = bus_i.wdata[B_CLIP_MASK];
         s_d.done_mask  = bus_i.wdata[B_DONE_MASK];
         s_d.blank_mask = bus_i.wdata[B_BLANK_MASK];
         s_d.gie = bus_i.wdata[B_GIE];
      end
      s_d.rdata = '0;
      if (bus_i.rd && hit(bus_i.addr, GSI_ADDR_CSR_TWO))
      begin
         s_d.rdata[B_BLANK_LVL]  = raster_n_i.vertical_blank_signal;
         s_d.rdata[B_VSYNC_LVL]  = raster_n_i.vert_sync;
         s_d.rdata[B_HSYNC_LVL]  = raster_n_i.horiz_sync;
         s_d.rdata[B_DAC]        = s_q.strap.dac_type_flag;
         s_d.rdata[B_MASTER]     = s_q.strap.master_role_flag;
         s_d.rdata[B_CLF]        = clf;
         s_d.rdata[B_CLIP_MASK]  = s_q.clip_mask;
         s_d.rdata[B_DDF]        = ddf;
         s_d.rdata[B_DONE_MASK]  = s_q.done_mask;
         s_d.rdata[B_VBF]        = vbf;
         s_d.rdata[B_BLANK_MASK] = s_q.blank_mask;
         s_d.rdata[B_GIE]        = s_q.gie;
         s_d.rdata[B_WAIT]       = s_q.strap.extra_wait_flag;
         s_d.rdata[B_POSH:B_POSL] = s_q.strap.position_code;
         s_d.rdata[B_FBH:B_FBL]   = s_q.strap.framebuf_size_code;
         s_d.rdata[B_PDH:B_PDL]   = s_q.strap.pixel_depth_code;
      end
      else if (bus_i.rd && hit(bus_i.addr, GSI_ADDR_CSR_ONE))
      begin
         s_d.rdata[B_BUSY] = draw_i.busy;
      end
      s_d.irq = s_q.gie && ((clf && s_q.clip_mask) || (ddf && s_q.done_mask) || (!vbf && s_q.blank_mask));
      s_d.base       = base_c;
      s_d.base_ok    = base_ok_c;
      s_d.blank_prev = raster_n_i.vertical_blank_signal;
   end
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         s_q <= '{ph: ST_CAPTURE, strap: '0, clip_mask: 1'b0, done_mask: 1'b0, blank_mask: 1'b0,
                  gie: 1'b0, blank_prev: 1'b1, rdata: '0, irq: 1'b0, base: BASE_POS0, base_ok: 1'b1};
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign rdata_o      = s_q.rdata;
   assign irq_o        = s_q.irq;
   assign base_o       = s_q.base;
   assign base_valid_o = s_q.base_ok;
endmodule

// ### test/gsi_chk.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module gsi_chk
   import gsi_pkg::*;
(
   input  wire logic                clock_i,
   input  wire logic                nrst_i,
   input  wire gsi_pkg::gsi_bus_t    bus_i,
   input  wire gsi_pkg::gsi_raster_t raster_n_i,
   input  wire gsi_pkg::gsi_draw_t   draw_i,
   input  wire gsi_pkg::gsi_strap_t  strap_i,
   input  wire logic [GSI_DW-1:0]   rdata_o,
   input  wire logic                irq_o,
   input  wire logic [31:0]         base_o,
   input  wire logic                base_valid_o
);
   gsi_strap_t s_q;
   logic [1:0] n_q;
   logic       rd2;
   logic       rd0;
   logic       wr2;
   logic [3:0] mw;
   assign rd2 = bus_i.rd && bus_i.addr == GSI_ADDR_CSR_TWO;
   assign rd0 = bus_i.rd && bus_i.addr == GSI_ADDR_CSR_ONE;
   assign wr2 = bus_i.wr && bus_i.addr == GSI_ADDR_CSR_TWO;
   assign mw  = {bus_i.wdata[13], bus_i.wdata[11], bus_i.wdata[9:8]};
   // straps seen at first edge after reset
   always_ff @(posedge clock_i)
   begin
      n_q <= !nrst_i ? 2'h0 : n_q + {1'b0, n_q != 2'h3};
      if (nrst_i && n_q == 2'h0)
         s_q <= strap_i;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   a_live_raster: assert property (rd2 |=> rdata_o[19:17] == $past(raster_n_i))
      else $error("raster bits wrong");
   a_strap_bits: assert property (rd2 && n_q == 2'h3 |=> rdata_o[16:15] == s_q[9:8] && rdata_o[7:0] == s_q[7:0])
      else $error("strap bits wrong");
   a_base_map: assert property (n_q == 2'h3 |-> base_valid_o == (s_q.position_code != 2'h3)
      && (!base_valid_o || base_o == BASE_POS0 + {22'h0, s_q.position_code, 8'h00}))
      else $error("base decode wrong");
   a_mask_back: assert property (wr2 ##1 rd2 |=> {rdata_o[13], rdata_o[11], rdata_o[9:8]} == $past(mw, 2))
      else $error("mask readback wrong");
   a_clip_set: assert property (draw_i.clip ##1 rd2 |=> rdata_o[14])
      else $error("clip flag not set");
   a_done_set: assert property (draw_i.done ##1 rd2 |=> rdata_o[12])
      else $error("done flag not set");
   a_blank_seen: assert property ($fell(raster_n_i.vertical_blank_signal) ##1 rd2 |=> !rdata_o[10])
      else $error("blank flag not set");
   a_busy_bit: assert property (rd0 |=> rdata_o == {30'h0, $past(draw_i.busy), 1'b0})
      else $error("busy bit wrong");
endmodule
bind gsi_top gsi_chk u_chk (.clock_i, .nrst_i, .bus_i, .raster_n_i, .draw_i, .strap_i, .rdata_o, .irq_o,
   .base_o, .base_valid_o);

// ### test/gsi_top_test.sv
`timescale 1ns/1ps
// ==========================================================
// bench
module gsi_top_test;
   import gsi_pkg::*;
   logic              clock_i = 1'b0;
   logic              nrst_i = 1'b0;
   gsi_bus_t          bus_i = '0;
   gsi_raster_t       raster_n_i = 3'h7;
   gsi_draw_t         draw_i = '0;
   gsi_strap_t        strap_i = {1'b1, 1'b0, 1'b1, POS_BLUE, FB_MAX, PD_24BPP};
   logic [GSI_DW-1:0] rdata_o;
   logic              irq_o;
   logic [31:0]       base_o;
   logic              base_valid_o;
   logic [31:0]       qe[$];
   logic [31:0]       qm[$];
   logic [31:0]       seed = 32'h1A;
   logic [31:0]       w;
   logic [31:0]       f;
   logic              rd_seen = 1'b0;
   logic              irq_s = 1'b0;
   logic [32:0]       base_s = '0;
   int                error_cnt = 0;
   int                samples_checked = 0;
   int                fb;
   int                mb;
   gsi_top dut (.clock_i, .nrst_i, .bus_i, .raster_n_i, .draw_i, .strap_i, .rdata_o, .irq_o, .base_o,
      .base_valid_o);
   initial
      forever #10 clock_i = ~clock_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic go(input logic [1:0] s, input logic [31:0] d, input logic [3:0] a);
      bus_i.addr <= a;
      bus_i.wdata <= d;
      {bus_i.wr, bus_i.rd} <= s;
      @(posedge clock_i);
   endtask
   task automatic cyc(input int n);
      {bus_i.wr, bus_i.rd} <= 2'h0;
      repeat (n) @(posedge clock_i);
   endtask
   task automatic wr(input logic [31:0] d);
      go(2'h2, d, GSI_ADDR_CSR_TWO);
   endtask
   task automatic rd(input logic [31:0] e, m = 32'hFFFFFFFF, input logic [3:0] a = GSI_ADDR_CSR_TWO);
      qe.push_back(e);
      qm.push_back(m);
      go(2'h1, rnd(), a);
   endtask
   task automatic chk_rd(input logic [31:0] e, m);
      samples_checked++;
      if ((rdata_o & m) !== e)
      begin
         error_cnt++;
         $display("wrong value rdata exp %h got %h", e, rdata_o & m);
      end
   endtask
   task automatic chk_irq(input logic e);
      samples_checked++;
      if (irq_s !== e)
      begin
         error_cnt++;
         $display("wrong value irq exp %b got %b", e, irq_s);
      end
   endtask
   task automatic chk_base(input logic [32:0] e);
      samples_checked++;
      if (base_s !== e)
      begin
         error_cnt++;
         $display("wrong value base exp %h got %h", e, base_s);
      end
   endtask
   task automatic summarize();
      $display("checked %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // result watcher
   always @(negedge clock_i)
   begin
      irq_s = irq_o;
      base_s = {base_valid_o, base_o};
      if (rd_seen)
         chk_rd(qe.pop_front(), qm.pop_front());
      rd_seen = bus_i.rd;
   end
   initial
   begin
      repeat (3000) @(posedge clock_i);
      error_cnt++;
      summarize();
   end
   initial
   begin
      cyc(6);
      nrst_i <= 1'b1;
      cyc(3);
      chk_base({1'b1, BASE_POS1});
      rd(32'h000F04B2);
      strap_i.pixel_depth_code <= PD_8BPP;
      go(2'h2, 32'hFFFFFFFF, 4'h5);
      rd(32'h0, 32'hFFFFFFFF, 4'h5);
      rd(32'h000F04B2);
      draw_i.busy <= 1'b1;
      rd(32'h2, 32'hFFFFFFFF, GSI_ADDR_CSR_ONE);
      draw_i.busy <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         raster_n_i <= i[2:0];
         rd(32'(i) << 17, 32'h000E0000);
      end
      raster_n_i <= 3'h7;
      rd(32'h0, 32'h400);
      repeat (4)
      begin
         w = (rnd() & ~32'h5000) | 32'h400;
         wr(w);
         rd(32'h000F04B2 | (w & 32'h2B00));
      end
      for (int i = 0; i < 3; i++)
      begin
         fb = 14 - 2 * i;
         mb = fb - 1;
         f = (i == 2) ? 32'h0 : 32'h1 << fb;
         draw_i <= {i == 0, i == 1, 1'b0};
         raster_n_i <= {i != 2, 2'h3};
         wr(32'h5000 | 32'h1 << mb);
         draw_i <= '0;
         raster_n_i <= 3'h7;
         rd(f, 32'h1 << fb);
         cyc(3);
         chk_irq(1'b0);
         wr(32'h5100 | 32'h1 << mb);
         cyc(3);
         chk_irq(1'b1);
         wr(32'h5100);
         cyc(3);
         chk_irq(1'b0);
         wr(32'h0500 | 32'h1 << mb);
         cyc(3);
         chk_irq(1'b0);
         rd(f ^ (32'h1 << fb), 32'h1 << fb);
      end
      // mid-run resets with other straps
      for (int k = 0; k < 2; k++)
      begin
         strap_i <= {1'b0, 1'b1, 1'b0, (k == 0) ? POS_GREEN : POS_RED, 3'h1, PD_8BPP};
         nrst_i <= 1'b0;
         cyc(2);
         nrst_i <= 1'b1;
         cyc(3);
         chk_base({1'b1, (k == 0) ? BASE_POS2 : BASE_POS0});
         rd(32'h000E8404 | ((k == 0) ? 32'h40 : 32'h0));
      end
      cyc(3);
      summarize();
   end
endmodule
